// file: logic/wwt_consts.vh
`ifndef WWT_CONSTS_VH
`define WWT_CONSTS_VH
// Register byte offsets
`define WWT_CTRL_OFS                  8'h00
`define WWT_CONFIG_OFS                8'h04
`define WWT_EARLY_WARNING_CONTROL_OFS 8'h08
`define WWT_IRQ_ENABLE_CLEAR_OFS      8'h0c
`define WWT_IRQ_ENABLE_SET_OFS        8'h10
`define WWT_IRQ_STATUS_OFS            8'h14
`define WWT_SERVICE_OFS               8'h18
`define WWT_COUNT_OFS                 8'h1c
// Field positions
`define WWT_CTRL_ENABLE_BIT           0
`define WWT_CTRL_WINDOW_BIT           1
`define WWT_OPEN_PERIOD_LSB           0
`define WWT_CLOSED_PERIOD_LSB         4
`define WWT_EARLY_WARNING_BIT         0
// Reset values
`define WWT_CTRL_RST                  2'h0
`define WWT_CONFIG_RST                8'hbb
`define WWT_EARLY_WARNING_CTRL_RST    4'hb
`define WWT_IRQ_ENABLE_RST            1'h0
// Service key
`define WWT_SERVICE_KEY               8'ha5
// Timing: period base 8 ms doubled per setting, settings 0..11
`define WWT_PERIOD_BASE_MS            16'h0008
`define WWT_PERIOD_SEL_MAX            4'hb
`define WWT_TICK_US                   1000
`define WWT_CLK_MHZ                   50
`define WWT_TICK_CYCLES               (`WWT_TICK_US * `WWT_CLK_MHZ)
`endif

// file: logic/wwt_top.v
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Contract
// [RULE1] Reset issued when period elapses unserviced
// [RULE2] Key 0xA5 restarts the period
// [RULE3] Any other service value resets immediately
// [RULE4] Twelve periods from 8 ms to 16 s
// [RULE5] Early warning enable off after reset
// [RULE6] Enable clear also visible in set
// [RULE7] Normal mode warning at programmed offset
// [RULE8] Window mode accepts key only when open
// [RULE9] Key during closed window resets system
// [RULE10] Window timeout is closed plus open
// [RULE11] Closed from window field, open from period
// [RULE12] Window mode warning when window opens
// [RULE13] Mode bit selects normal or window
`include "wwt_consts.vh"

module wwt_top #(
  parameter TICK_CYCLES = `WWT_TICK_CYCLES
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  output wire        irq,
  output wire        sys_reset_req
);

  ////////////////////////////////////////////////////////////////////////////
  localparam [3:0] ST_IDLE   = 4'h1;
  localparam [3:0] ST_CLOSED = 4'h2;
  localparam [3:0] ST_OPEN   = 4'h4;
  localparam [3:0] ST_FIRED  = 4'h8;

  reg         ack_ff;
  reg  [1:0]  ctrl_ff;
  reg  [7:0]  config_ff;
  reg  [3:0]  warn_ofs_ff;
  reg         warn_en_ff;
  reg         warn_stat_ff;
  reg  [3:0]  state_ff;
  reg  [3:0]  nxt_state;
  reg  [15:0] ms_cnt_ff;
  reg  [15:0] nxt_ms_cnt;
  reg  [31:0] pre_cnt_ff;
  reg         reset_req_ff;
  reg         nxt_reset_req;
  reg         warn_evt;

  wire        req;
  wire        take;
  wire        wr_take;
  wire        rd_take;
  wire        wr_lo;
  wire [7:0]  wbyte;
  wire        enable;
  wire        window_mode;
  wire [3:0]  open_sel_raw;
  wire [3:0]  closed_sel_raw;
  wire [3:0]  open_sel;
  wire [3:0]  closed_sel;
  wire [3:0]  warn_sel;
  wire [15:0] open_len;
  wire [15:0] closed_len;
  wire [15:0] warn_len;
  wire [15:0] ms_inc;
  wire        tick;
  wire        svc_wr;
  wire        key_ok;
  wire        restart;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle per access
  assign req         = read | write;
  assign waitrequest = req & ~ack_ff;
  assign take        = req & ack_ff;
  assign wr_take     = take & write;
  assign rd_take     = take & read;
  assign wr_lo       = wr_take & byteenable[0];
  assign wbyte       = writedata[7:0];

  always @(posedge core_clk)
  begin
    if (rst)
      ack_ff <= 1'b0;
    else
      ack_ff <= req & ~ack_ff;
  end

  // Read data captured in the wait cycle, stands at the taking edge
  always @(posedge core_clk)
  begin
    if (rst)
      readdata <= 32'h0000_0000;
    else if (read & ~ack_ff)
    begin
      case (address)
        `WWT_CTRL_OFS:                  readdata <= {30'h0, ctrl_ff};
        `WWT_CONFIG_OFS:                readdata <= {24'h0, config_ff};
        `WWT_EARLY_WARNING_CONTROL_OFS: readdata <= {28'h0, warn_ofs_ff};
        // Both enable views show the same flop
        `WWT_IRQ_ENABLE_CLEAR_OFS:      readdata <= {31'h0, warn_en_ff};
        `WWT_IRQ_ENABLE_SET_OFS:        readdata <= {31'h0, warn_en_ff};
        `WWT_IRQ_STATUS_OFS:            readdata <= {31'h0, warn_stat_ff};
        `WWT_COUNT_OFS:                 readdata <= {16'h0, ms_cnt_ff};
        default:                        readdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  assign enable      = ctrl_ff[`WWT_CTRL_ENABLE_BIT];
  // [RULE13] mode select bit
  assign window_mode = ctrl_ff[`WWT_CTRL_WINDOW_BIT];

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_ff     <= `WWT_CTRL_RST;
      config_ff   <= `WWT_CONFIG_RST;
      warn_ofs_ff <= `WWT_EARLY_WARNING_CTRL_RST;
    end
    else if (wr_lo)
    begin
      case (address)
        `WWT_CTRL_OFS:                  ctrl_ff     <= wbyte[1:0];
        `WWT_CONFIG_OFS:                config_ff   <= wbyte;
        `WWT_EARLY_WARNING_CONTROL_OFS: warn_ofs_ff <= wbyte[3:0];
        default:                        ctrl_ff     <= ctrl_ff;
      endcase
    end
  end

  // [RULE5] enable off after reset, set by 1
  // [RULE6] clear register drops the same flop
  always @(posedge core_clk)
  begin
    if (rst)
      warn_en_ff <= `WWT_IRQ_ENABLE_RST;
    else if (wr_lo && address == `WWT_IRQ_ENABLE_SET_OFS && wbyte[`WWT_EARLY_WARNING_BIT])
      warn_en_ff <= 1'b1;
    else if (wr_lo && address == `WWT_IRQ_ENABLE_CLEAR_OFS && wbyte[`WWT_EARLY_WARNING_BIT])
      warn_en_ff <= 1'b0;
  end

  // Sticky status; a new event beats the clearing read
  always @(posedge core_clk)
  begin
    if (rst)
      warn_stat_ff <= 1'b0;
    else if (warn_evt)
      warn_stat_ff <= 1'b1;
    else if (rd_take && address == `WWT_IRQ_STATUS_OFS)
      warn_stat_ff <= 1'b0;
  end

  // Level output, drops on read clear or mask
  assign irq = warn_stat_ff & warn_en_ff;

  ////////////////////////////////////////////////////////////////////////////
  // [RULE4] period settings clamped to twelve steps
  assign open_sel_raw   = config_ff[`WWT_OPEN_PERIOD_LSB +: 4];
  // [RULE11] closed length from window field
  assign closed_sel_raw = config_ff[`WWT_CLOSED_PERIOD_LSB +: 4];
  // Clamp holds settings 12..15 at the longest period
  assign open_sel   = (open_sel_raw > `WWT_PERIOD_SEL_MAX) ? `WWT_PERIOD_SEL_MAX : open_sel_raw;
  assign closed_sel = (closed_sel_raw > `WWT_PERIOD_SEL_MAX) ? `WWT_PERIOD_SEL_MAX : closed_sel_raw;
  assign warn_sel   = (warn_ofs_ff > `WWT_PERIOD_SEL_MAX) ? `WWT_PERIOD_SEL_MAX : warn_ofs_ff;
  assign open_len   = `WWT_PERIOD_BASE_MS << open_sel;
  assign closed_len = `WWT_PERIOD_BASE_MS << closed_sel;
  assign warn_len   = `WWT_PERIOD_BASE_MS << warn_sel;
  assign ms_inc     = ms_cnt_ff + 16'h0001;

  // Service decode
  assign svc_wr  = wr_lo && (address == `WWT_SERVICE_OFS);
  // [RULE2] key compare
  assign key_ok  = (wbyte == `WWT_SERVICE_KEY);
  // [RULE8] key counts when open
  assign restart = svc_wr & key_ok & (state_ff == ST_OPEN);

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond prescaler, realigned on each new period
  assign tick = (pre_cnt_ff == TICK_CYCLES - 1);

  always @(posedge core_clk)
  begin
    if (rst || !enable || restart || state_ff == ST_IDLE)
      pre_cnt_ff <= 32'h0000_0000;
    else if (tick)
      pre_cnt_ff <= 32'h0000_0000;
    else
      pre_cnt_ff <= pre_cnt_ff + 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period state machine
  always @*
  begin
    nxt_state     = state_ff;
    nxt_ms_cnt    = ms_cnt_ff;
    nxt_reset_req = reset_req_ff;
    warn_evt      = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_ms_cnt = 16'h0000;
        if (enable)
          nxt_state = window_mode ? ST_CLOSED : ST_OPEN;
      end
      ST_CLOSED:
      begin
        if (tick)
          nxt_ms_cnt = ms_inc;
        // [RULE10] closed phase then open phase
        if (tick && ms_inc == closed_len)
        begin
          nxt_state  = ST_OPEN;
          nxt_ms_cnt = 16'h0000;
          // [RULE12] warning as window opens
          warn_evt   = 1'b1;
        end
      end
      ST_OPEN:
      begin
        if (tick)
          nxt_ms_cnt = ms_inc;
        // [RULE7] normal mode warning at offset
        if (tick && !window_mode && ms_inc == warn_len && warn_len < open_len)
          warn_evt = 1'b1;
        // [RULE1] unserviced period ends in reset
        if (tick && ms_inc == open_len)
        begin
          nxt_state     = ST_FIRED;
          nxt_reset_req = 1'b1;
        end
      end
      ST_FIRED:
        nxt_reset_req = 1'b1;
      default:
        nxt_state = ST_IDLE;
    endcase
    if (!enable && state_ff != ST_FIRED)
    begin
      nxt_state  = ST_IDLE;
      nxt_ms_cnt = 16'h0000;
    end
    // Bad key acts even while disabled
    if (svc_wr && state_ff != ST_FIRED)
    begin
      if (!key_ok)
      begin
        // [RULE3] wrong value, immediate reset
        nxt_state     = ST_FIRED;
        nxt_reset_req = 1'b1;
      end
      else if (state_ff == ST_CLOSED)
      begin
        // [RULE9] service while closed resets
        nxt_state     = ST_FIRED;
        nxt_reset_req = 1'b1;
      end
      else if (restart)
      begin
        // [RULE2] valid key restarts period
        // [RULE8] accepted only in open phase
        nxt_state  = window_mode ? ST_CLOSED : ST_OPEN;
        nxt_ms_cnt = 16'h0000;
        warn_evt   = 1'b0;
        // Key landing on the expiring edge still counts
        nxt_reset_req = reset_req_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase and reset request registers
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      state_ff     <= ST_IDLE;
      ms_cnt_ff    <= 16'h0000;
      reset_req_ff <= 1'b0;
    end
    else
    begin
      state_ff     <= nxt_state;
      ms_cnt_ff    <= nxt_ms_cnt;
      reset_req_ff <= nxt_reset_req;
    end
  end

  // Held until the system reset comes back on rst
  assign sys_reset_req = reset_req_ff;

endmodule // wwt_top

// file: verification/wwt_top_sva.sv
`timescale 1ns/1ps
module wwt_top_sva #(
  parameter TICK_CYCLES = 4
) (
  input wire        core_clk,
  input wire        rst,
  input wire [7:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [3:0]  byteenable,
  input wire [31:0] readdata,
  input wire        waitrequest,
  input wire        irq,
  input wire        sys_reset_req
);
  // Transfers taken at this edge
  wire take_wr = write && !waitrequest && byteenable[0];
  wire take_rd = read && !waitrequest;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////
  property p_req_hold; sys_reset_req |=> sys_reset_req; endproperty
  a_req_hold: assert property (p_req_hold) else $error("reset request dropped");
  property p_bad_key; take_wr && address == 8'h18 && writedata[7:0] != 8'ha5 |=> sys_reset_req; endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key ignored");
  property p_rst_quiet; $fell(rst) |-> !irq && !sys_reset_req; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  property p_clr_irq; take_wr && address == 8'h0c && writedata[0] |=> (!irq) [*3]; endproperty
  a_clr_irq: assert property (p_clr_irq) else $error("irq after enable clear");
  property p_en_seen; take_rd && address == 8'h0c && irq |-> readdata[0]; endproperty
  a_en_seen: assert property (p_en_seen) else $error("enable not visible");
  property p_one_wait; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
  property p_wait_first; $rose(read || write) |-> waitrequest; endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
  property p_unmapped; take_rd && address == 8'h20 |-> readdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_reset: cover property ($rose(sys_reset_req));
  c_irq: cover property ($rose(irq));
  c_key: cover property (take_wr && address == 8'h18 && writedata[7:0] == 8'ha5);
endmodule // wwt_top_sva

bind wwt_top wwt_top_sva #(.TICK_CYCLES(TICK_CYCLES)) wwt_top_sva_inst (.core_clk(core_clk), .rst(rst),
  .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .sys_reset_req(sys_reset_req));

// file: verification/wwt_top_tb.sv
`timescale 1ns/1ps
module wwt_top_tb;
  // Short ms tick keeps the run small
  localparam TK = 4;
  reg         core_clk = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  address = 8'h00;
  reg         read = 1'b0;
  reg         write = 1'b0;
  reg  [31:0] writedata = 32'h0;
  reg  [3:0]  byteenable = 4'hf;
  wire [31:0] readdata;
  wire        waitrequest;
  wire        irq;
  wire        sys_reset_req;
  reg  [31:0] expq[$];
  reg  [31:0] v;
  integer     miscompares = 0;
  integer     compares = 0;
  integer     cyc = 0;
  always #10 core_clk = ~core_clk;
  wwt_top #(.TICK_CYCLES(TK)) wwt_top_inst (.core_clk(core_clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .irq(irq), .sys_reset_req(sys_reset_req));
  //////////////////////////////////////////////////////////////////
  task end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  // Request held until waitrequest is sampled low at a rising edge
  task bus(input [7:0] a, input [31:0] d, input rw);
    address <= a;
    writedata <= d;
    read <= ~rw;
    write <= rw;
    @(posedge core_clk);
    while (waitrequest) @(posedge core_clk);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(a, d, 1'b1);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    expq.push_back(e);
    bus(a, 32'h0, 1'b0);
  endtask
  task sr(input e);
    @(negedge core_clk);
    chk("sys_reset_req", sys_reset_req, e);
    @(posedge core_clk);
  endtask
  task ir(input e);
    @(negedge core_clk);
    chk("irq", irq, e);
    @(posedge core_clk);
  endtask
  // Quiet just before the period ends, reset just after
  task to_chk(input integer n);
    tick(n - 8);
    sr(1'b0);
    tick(11);
    sr(1'b1);
  endtask
  task do_rst;
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
  endtask
  //////////////////////////////////////////////////////////////////
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (read && !waitrequest)
      chk("readdata", readdata, expq.pop_front());
    if (cyc == 4000)
    begin
      miscompares = miscompares + 1;
      end_sim;
    end
  end
  initial
  begin
    v = $urandom(32'h111ff382);
    tick(6);
    rst <= 1'b0;
    tick(1);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'hbb);
    rd(8'h08, 32'hb);
    rd(8'h10, 32'h0);
    rd(8'h20, 32'h0);
    // Write without the low lane enable must be ignored
    byteenable <= 4'he;
    wr(8'h00, 32'h1);
    byteenable <= 4'hf;
    rd(8'h00, 32'h0);
    v = $urandom % 2;
    wr(8'h04, v);
    wr(8'h00, 32'h1);
    to_chk((32'h8 << v) * TK);
    do_rst;
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h1);
    repeat (3)
    begin
      tick(20);
      wr(8'h18, 32'ha5);
    end
    sr(1'b0);
    to_chk(8 * TK);
    do_rst;
    v = $urandom & 32'hff;
    if (v == 32'ha5)
      v = 32'h5a;
    wr(8'h18, v);
    sr(1'b1);
    do_rst;
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h1);
    tick(40);
    ir(1'b0);
    rd(8'h10, 32'h0);
    wr(8'h10, 32'h1);
    ir(1'b1);
    rd(8'h0c, 32'h1);
    wr(8'h0c, 32'h1);
    ir(1'b0);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h1);
    rd(8'h14, 32'h0);
    do_rst;
    wr(8'h10, 32'h1);
    wr(8'h04, 32'h10);
    wr(8'h00, 32'h3);
    tick(50);
    ir(1'b0);
    sr(1'b0);
    tick(20);
    ir(1'b1);
    wr(8'h18, 32'ha5);
    sr(1'b0);
    rd(8'h14, 32'h1);
    wr(8'h18, 32'ha5);
    sr(1'b1);
    do_rst;
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h3);
    to_chk(16 * TK);
    end_sim;
  end
endmodule // wwt_top_tb
